// *** rtsc_pkg.sv ***
// constants, state type and timing counts for the radio tx state control
`default_nettype none
package rtsc_pkg;
  typedef enum logic [3:0] {
    ST_WAKE, ST_IDLE, ST_OSC_OFF, ST_SLEEP, ST_CAL_MAN, ST_CAL_TX,
    ST_SETTLE, ST_TX, ST_SYNTH_READY, ST_TX_END, ST_CAL_END, ST_UNDERFLOW
  } rtsc_state_t;
  localparam int TMR_W = 15;
  localparam logic [14:0] IDLE_TO_TX_CYCLES = 15'h08FA;
  localparam logic [14:0] TX_TO_IDLE_CYCLES = 15'h0002;
  localparam logic [14:0] CAL_CYCLES_DEFAULT = 15'h4933;
  localparam logic [14:0] XOSC_START_DEFAULT = 15'h0040;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] THR_BASE = 7'h3D;
  localparam logic [3:0] STATUS_FILL_MAX = 4'hF;
  localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
  localparam logic [1:0] AUTOCAL_ON_START = 2'h1;
  localparam logic [1:0] AUTOCAL_ON_END = 2'h2;
  localparam logic [1:0] AUTOCAL_FOURTH_END = 2'h3;
  localparam logic [1:0] AFTER_TX_IDLE = 2'h0;
  localparam logic [1:0] AFTER_TX_SYNTH = 2'h1;
  localparam logic [1:0] FOURTH_LAST = 2'h3;
  localparam logic [5:0] PIN_SEL_THRESH = 6'h02;
  localparam logic [5:0] PIN_SEL_LOCK = 6'h0A;
  localparam logic [5:0] CAL_RESULT_UNLOCKED = 6'h3F;
  localparam logic [5:0] CAL_RESULT_LOCKED_DEFAULT = 6'h20;
  localparam logic [8:0] SPACING_OFFSET = 9'h100;
endpackage
`default_nettype wire

// *** rtsc_tmr_if.sv ***
// carrier between state control and its cycle timer
`timescale 1ns/1ps
`default_nettype none
interface rtsc_tmr_if;
  logic start;
  logic [14:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

// *** rtsc_timer.sv ***
// down counter timing state transitions in crystal cycles
`timescale 1ns/1ps
`default_nettype none
module rtsc_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control
  rtsc_tmr_if.tmr tmr
);
  logic [14:0] cnt;
  logic busy;
  // done falls on the edge that ends a span of load cycles
  assign tmr.done = busy && (cnt == 15'h0001);
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt <= 15'h0000;
      busy <= 1'b0;
    end
    else if (tmr.start)
    begin
      cnt <= tmr.load;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      cnt <= cnt - 15'h0001;
      busy <= (cnt != 15'h0001);
    end
  end
endmodule
`default_nettype wire

// *** rtsc_top.sv ***
// radio tx state machine, oscillator/regulator sequencing, tx fifo, carrier word
`timescale 1ns/1ps
`default_nettype none
module rtsc_top #(
  parameter logic [14:0] CAL_CYCLES = rtsc_pkg::CAL_CYCLES_DEFAULT,
  parameter logic [14:0] XOSC_START_CYCLES = rtsc_pkg::XOSC_START_DEFAULT,
  parameter logic [5:0] CAL_RESULT_LOCKED = rtsc_pkg::CAL_RESULT_LOCKED_DEFAULT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // chip select pin, active low
  input wire logic i_chip_select_line_n,
  // command strobes, one-cycle pulses
  input wire logic i_strobe_osc_off,
  input wire logic i_strobe_power_down,
  input wire logic i_strobe_go_idle,
  input wire logic i_strobe_transmit,
  input wire logic i_strobe_calibrate,
  // modulator events
  input wire logic i_packet_done,
  input wire logic i_fifo_rd,
  // fifo write side
  input wire logic i_fifo_wr,
  input wire logic [7:0] i_fifo_wdata,
  // spi header status
  input wire logic i_header_active,
  input wire logic i_header_rw,
  // configuration
  input wire logic [1:0] i_autocal_select,
  input wire logic [1:0] i_after_tx_state_select,
  input wire logic [3:0] i_fill_threshold_select,
  input wire logic [23:0] i_base_freq,
  input wire logic [7:0] i_channel_index,
  input wire logic [7:0] i_spacing_mantissa,
  input wire logic [1:0] i_spacing_exponent,
  input wire logic [1:0][5:0] i_output_pin_select,
  // power and status
  output logic o_osc_enable,
  output logic o_core_reg_enable,
  output logic o_chip_ready_indicator_n,
  output logic o_config_defaults,
  output logic [3:0] o_state,
  output logic o_tx_underflow,
  output logic [5:0] o_synth_cal_result,
  // fifo and frequency
  output logic [7:0] o_fifo_rdata,
  output logic [6:0] o_tx_fill_count,
  output logic [3:0] o_status_fill,
  output logic o_threshold_flag,
  output logic [1:0] o_general_output_pin,
  output logic [26:0] o_carrier_word
);
  rtsc_pkg::rtsc_state_t state;
  rtsc_pkg::rtsc_state_t next_state;
  rtsc_tmr_if tmr ();
  logic cs_meta;
  logic cs_hi;
  logic [1:0] hdr_meta;
  logic [1:0] hdr_sync;
  logic boot;
  wire [1:0] pin_val;
  logic osc_on;
  logic reg_on;
  logic from_sleep;
  logic cal_valid;
  logic [1:0] tx_auto_cnt;
  logic [7:0] mem [rtsc_pkg::FIFO_DEPTH];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] fill;
  logic [14:0] cal_len;

  rtsc_timer u_timer (
    .i_clk (i_clk),
    .i_arst_n (i_arst_n),
    .tmr (tmr.tmr)
  );

  ////////////////////////////////////////////////////////////////
  // chip select and spi header synchronisers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cs_meta <= 1'b1;
      cs_hi <= 1'b1;
      hdr_meta <= 2'h0;
      hdr_sync <= 2'h0;
    end
    else
    begin
      cs_meta <= i_chip_select_line_n;
      cs_hi <= cs_meta;
      hdr_meta <= {i_header_active, i_header_rw};
      hdr_sync <= hdr_meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // decode
  wire st_idle = (state == rtsc_pkg::ST_IDLE);
  wire st_tx = (state == rtsc_pkg::ST_TX);
  wire st_parked = (state == rtsc_pkg::ST_OSC_OFF) || (state == rtsc_pkg::ST_SLEEP);
  wire in_cal = (state == rtsc_pkg::ST_CAL_MAN) || (state == rtsc_pkg::ST_CAL_TX) ||
    (state == rtsc_pkg::ST_CAL_END);
  wire fifo_full = (fill == 7'(rtsc_pkg::FIFO_DEPTH));
  wire fifo_empty = (fill == 7'h00);
  wire uf_set = st_tx && i_fifo_rd && fifo_empty;
  wire rd_en = st_tx && i_fifo_rd && !fifo_empty;
  // writes past full are dropped; keeping within free space is the host's job
  wire wr_en = i_fifo_wr && !fifo_full;
  wire cal_on_end = (i_autocal_select == rtsc_pkg::AUTOCAL_ON_END) ||
    ((i_autocal_select == rtsc_pkg::AUTOCAL_FOURTH_END) &&
    (tx_auto_cnt == rtsc_pkg::FOURTH_LAST));
  wire auto_to_idle = st_tx && i_packet_done && !uf_set && !i_strobe_go_idle &&
    (i_after_tx_state_select == rtsc_pkg::AFTER_TX_IDLE);
  // a parked state sees strobes only while selected with the oscillator up;
  // otherwise idle would be reached with the oscillator stopped
  wire go_idle = i_strobe_go_idle && (state != rtsc_pkg::ST_WAKE) &&
    !(st_parked && (!osc_on || cs_hi));
  wire wake = st_parked && !osc_on && !cs_hi;
  wire woke = (state == rtsc_pkg::ST_WAKE) && tmr.done;
  wire next_osc_on = (!osc_on && !cs_hi) ? 1'b1 :
    (st_parked && cs_hi) ? 1'b0 : osc_on;
  wire next_reg_on = !cs_hi ? 1'b1 :
    (state == rtsc_pkg::ST_SLEEP) ? 1'b0 : reg_on;
  wire flush = (woke && from_sleep) || ((state == rtsc_pkg::ST_UNDERFLOW) && go_idle);
  wire [6:0] next_fill = flush ? 7'h00 :
    7'(fill + {6'h00, wr_en} - {6'h00, rd_en});
  wire [6:0] thr = 7'(rtsc_pkg::THR_BASE - {1'b0, i_fill_threshold_select, 2'b00});
  wire pll_lock = cal_valid && (st_tx || (state == rtsc_pkg::ST_SYNTH_READY));
  wire [8:0] spacing = rtsc_pkg::SPACING_OFFSET + {1'b0, i_spacing_mantissa};
  wire [16:0] chan_step = {9'h000, i_channel_index} * {8'h00, spacing};
  wire [26:0] next_carrier = {1'b0, i_base_freq, 2'b00} +
    (27'(chan_step) << i_spacing_exponent);

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_state = state;
    tmr.start = 1'b0;
    tmr.load = 15'h0000;
    case (state)
      rtsc_pkg::ST_WAKE:
        // reset lands here with the timer idle, so kick it once
        if (boot)
        begin
          tmr.start = 1'b1;
          tmr.load = XOSC_START_CYCLES;
        end
        else if (tmr.done)
          next_state = rtsc_pkg::ST_IDLE;
      rtsc_pkg::ST_IDLE:
        if (i_strobe_osc_off)
          next_state = rtsc_pkg::ST_OSC_OFF;
        else if (i_strobe_power_down)
          next_state = rtsc_pkg::ST_SLEEP;
        else if (i_strobe_calibrate)
        begin
          next_state = rtsc_pkg::ST_CAL_MAN;
          tmr.start = 1'b1;
          tmr.load = CAL_CYCLES;
        end
        else if (i_strobe_transmit)
        begin
          tmr.start = 1'b1;
          if (i_autocal_select == rtsc_pkg::AUTOCAL_ON_START)
          begin
            next_state = rtsc_pkg::ST_CAL_TX;
            tmr.load = CAL_CYCLES;
          end
          else
          begin
            next_state = rtsc_pkg::ST_SETTLE;
            tmr.load = rtsc_pkg::IDLE_TO_TX_CYCLES;
          end
        end
      rtsc_pkg::ST_CAL_TX:
        if (tmr.done)
        begin
          next_state = rtsc_pkg::ST_SETTLE;
          tmr.start = 1'b1;
          tmr.load = rtsc_pkg::IDLE_TO_TX_CYCLES;
        end
      rtsc_pkg::ST_SETTLE:
        if (tmr.done)
          next_state = rtsc_pkg::ST_TX;
      rtsc_pkg::ST_TX:
        if (uf_set)
          next_state = rtsc_pkg::ST_UNDERFLOW;
        else if (i_packet_done)
        begin
          if (i_after_tx_state_select == rtsc_pkg::AFTER_TX_IDLE)
          begin
            tmr.start = 1'b1;
            if (cal_on_end)
            begin
              next_state = rtsc_pkg::ST_CAL_END;
              tmr.load = CAL_CYCLES;
            end
            else
            begin
              next_state = rtsc_pkg::ST_TX_END;
              tmr.load = rtsc_pkg::TX_TO_IDLE_CYCLES;
            end
          end
          else if (i_after_tx_state_select == rtsc_pkg::AFTER_TX_SYNTH)
            next_state = rtsc_pkg::ST_SYNTH_READY;
        end
      rtsc_pkg::ST_SYNTH_READY:
        if (i_strobe_transmit)
          next_state = rtsc_pkg::ST_TX;
      rtsc_pkg::ST_CAL_MAN, rtsc_pkg::ST_TX_END, rtsc_pkg::ST_CAL_END:
        if (tmr.done)
          next_state = rtsc_pkg::ST_IDLE;
      rtsc_pkg::ST_OSC_OFF, rtsc_pkg::ST_SLEEP:
        if (wake)
        begin
          next_state = rtsc_pkg::ST_WAKE;
          tmr.start = 1'b1;
          tmr.load = XOSC_START_CYCLES;
        end
      rtsc_pkg::ST_UNDERFLOW:
        next_state = state;
      default:
        next_state = rtsc_pkg::ST_IDLE;
    endcase
    // forced idle skips every calibration
    if (go_idle)
    begin
      next_state = rtsc_pkg::ST_IDLE;
      tmr.start = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state, power and calibration bookkeeping
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= rtsc_pkg::ST_WAKE;
      osc_on <= 1'b1;
      reg_on <= 1'b1;
      from_sleep <= 1'b0;
      boot <= 1'b1;
    end
    else
    begin
      state <= next_state;
      boot <= 1'b0;
      osc_on <= next_osc_on;
      reg_on <= next_reg_on;
      if ((state == rtsc_pkg::ST_SLEEP) && cs_hi)
        from_sleep <= 1'b1;
      else if (woke)
        from_sleep <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cal_valid <= 1'b0;
      tx_auto_cnt <= 2'h0;
    end
    else
    begin
      if (woke && from_sleep)
        cal_valid <= 1'b0;
      else if (in_cal && tmr.done && !go_idle)
        cal_valid <= 1'b1;
      if (woke && from_sleep)
        tx_auto_cnt <= 2'h0;
      else if (auto_to_idle)
        tx_auto_cnt <= tx_auto_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // tx fifo; storage has no reset, the pointers define content
  always_ff @(posedge i_clk)
  begin
    if (wr_en)
      mem[wr_ptr] <= i_fifo_wdata;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      fill <= 7'h00;
      o_tx_underflow <= 1'b0;
      o_fifo_rdata <= 8'h00;
    end
    else
    begin
      wr_ptr <= flush ? 6'h00 : 6'(wr_ptr + {5'h00, wr_en});
      rd_ptr <= flush ? 6'h00 : 6'(rd_ptr + {5'h00, rd_en});
      fill <= next_fill;
      if (uf_set)
        o_tx_underflow <= 1'b1;
      else if (go_idle)
        o_tx_underflow <= 1'b0;
      if (rd_en)
        o_fifo_rdata <= mem[rd_ptr];
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_osc_enable <= 1'b1;
      o_core_reg_enable <= 1'b1;
      o_chip_ready_indicator_n <= 1'b1;
      o_config_defaults <= 1'b0;
      o_state <= 4'h0;
      o_synth_cal_result <= rtsc_pkg::CAL_RESULT_UNLOCKED;
      o_tx_fill_count <= 7'h00;
      o_status_fill <= 4'h0;
      o_threshold_flag <= 1'b0;
      o_carrier_word <= 27'h000_0000;
    end
    else
    begin
      o_osc_enable <= next_osc_on;
      o_core_reg_enable <= next_reg_on;
      // ready only once the oscillator has had its start-up time
      o_chip_ready_indicator_n <= !(next_osc_on && (next_state != rtsc_pkg::ST_WAKE));
      o_config_defaults <= woke && from_sleep;
      o_state <= 4'(next_state);
      o_synth_cal_result <= cal_valid ? CAL_RESULT_LOCKED : rtsc_pkg::CAL_RESULT_UNLOCKED;
      o_tx_fill_count <= next_fill;
      o_status_fill <= !(hdr_sync[1] && !hdr_sync[0]) ? 4'h0 :
        (next_fill > 7'(rtsc_pkg::STATUS_FILL_MAX)) ? rtsc_pkg::STATUS_FILL_MAX :
        next_fill[3:0];
      o_threshold_flag <= (next_fill >= thr);
      o_carrier_word <= next_carrier;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      assign pin_val[g] = (i_output_pin_select[g] == rtsc_pkg::PIN_SEL_LOCK) ? pll_lock :
        (i_output_pin_select[g] == rtsc_pkg::PIN_SEL_THRESH) ? (next_fill >= thr) : 1'b0;
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_general_output_pin <= 2'h0;
    else
      o_general_output_pin <= pin_val;
  end

  ////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cal_len <= 15'h0000;
    else
      cal_len <= in_cal ? 15'(cal_len + 15'h0001) : 15'h0000;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_two_cycle_end;
    (state == rtsc_pkg::ST_TX_END) ##1 (state == rtsc_pkg::ST_TX_END) ##1 st_idle;
  endsequence

  AST_GO_IDLE: assert property (go_idle |=> st_idle)
    else $error("idle strobe did not force idle");
  AST_PARK_FROM_IDLE: assert property ($rose(st_parked) |-> $past(st_idle))
    else $error("parked state entered from a state other than idle");
  AST_OSC_STOP: assert property (st_parked && cs_hi |=> !osc_on && !o_osc_enable)
    else $error("oscillator kept running after chip select release");
  AST_CS_WAKE: assert property (!osc_on && !cs_hi |=> osc_on ##1 !st_parked)
    else $error("chip select low did not restart oscillator");
  AST_REG_OFF: assert property ((state == rtsc_pkg::ST_SLEEP) && cs_hi |=> !o_core_reg_enable)
    else $error("core regulator stayed on in sleep");
  AST_TX_ENTRY: assert property (st_idle && i_strobe_transmit && !i_strobe_osc_off &&
    !i_strobe_power_down && !i_strobe_calibrate && !go_idle |=>
    (state == rtsc_pkg::ST_SETTLE) || (state == rtsc_pkg::ST_CAL_TX))
    else $error("transmit strobe ignored in idle");
  AST_TX_END: assert property ($rose(state == rtsc_pkg::ST_TX_END) && !i_strobe_go_idle |->
    s_two_cycle_end)
    else $error("tx to idle not two cycles");
  AST_NO_CAL_ON_IDLE: assert property (st_tx && i_strobe_go_idle |=> st_idle ##1 !in_cal)
    else $error("forced idle started a calibration");
  AST_CAL_LEN: assert property ($fell(in_cal) && !$past(i_strobe_go_idle) |->
    cal_len == CAL_CYCLES)
    else $error("calibration length wrong");
  AST_MAN_CAL: assert property (st_idle && i_strobe_calibrate && !i_strobe_osc_off &&
    !i_strobe_power_down && !go_idle |=> state == rtsc_pkg::ST_CAL_MAN)
    else $error("calibrate strobe ignored in idle");
  AST_UNDERFLOW: assert property (uf_set && !i_strobe_go_idle |=>
    (state == rtsc_pkg::ST_UNDERFLOW) && o_tx_underflow)
    else $error("underflow not reported");
  // flag and fill count load together, so compare against the current count
  AST_THRESH: assert property (##1 o_threshold_flag ==
    ({1'b0, fill} + 8'h04 * {4'h0, $past(i_fill_threshold_select)} >= 8'h3D))
    else $error("threshold flag disagrees with fill level");
endmodule
`default_nettype wire

// *** rtsc_host_model.sv ***
// host-side model: chip select, framed link clock and spi header phase
`timescale 1ns/1ps
`default_nettype none
module rtsc_host_model (
  // from the device
  input wire logic i_chip_ready_indicator_n,
  input wire logic [3:0] i_status_fill,
  // to the device
  output logic o_chip_select_line_n,
  output logic o_header_active,
  output logic o_header_rw
);
  logic sclk;
  logic link_on;

  initial
  begin
    sclk = 1'b0;
    link_on = 1'b0;
    o_chip_select_line_n = 1'b1;
    o_header_active = 1'b0;
    o_header_rw = 1'b0;
  end

  // link clock stands still outside frames
  always #100 sclk = link_on ? ~sclk : 1'b0;

  //////////////////////////////////////////////////
  task automatic select(output logic ready);
    int k;
    o_chip_select_line_n = 1'b0;
    ready = 1'b0;
    // no spi traffic until chip ready shows low
    for (k = 0; k < 400 && !ready; k++)
    begin
      #25;
      ready = (i_chip_ready_indicator_n === 1'b0);
    end
  endtask

  task automatic release_cs();
    o_chip_select_line_n = 1'b1;
  endtask

  task automatic header(input logic rw, output logic [3:0] status);
    link_on = 1'b1;
    o_header_rw = rw;
    o_header_active = 1'b1;
    repeat (4) @(posedge sclk);
    status = i_status_fill;
    repeat (4) @(posedge sclk);
    o_header_active = 1'b0;
    // released bit must not look valid
    o_header_rw = ~rw;
    link_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the radio tx state control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [14:0] CAL_N = 15'h0014;
  localparam int SETTLE_N = 2298;
  logic clk;
  logic arst_n;
  logic cs_n, wr, hdr_act, hdr_rw, osc_en, core_en, rdy_n, cfg_def, unf, thr_flag, seen_cfg, ok;
  // strobes: osc_off, power_down, go_idle, transmit, calibrate, packet_done, fifo_rd
  logic [6:0] strb;
  logic [7:0] wdata, chan, mant, rdata;
  logic [1:0] autocal, after_tx, expo, gpin;
  logic [3:0] thr, state, sfill, stat;
  logic [23:0] base;
  logic [1:0][5:0] pin_sel;
  logic [5:0] cal_res;
  logic [6:0] fill;
  logic [26:0] carrier;
  logic [7:0] q[$];
  int seed, bad_count, checks_done, i, n;

  rtsc_top #(.CAL_CYCLES(CAL_N), .XOSC_START_CYCLES(15'h0004)) rtsc_top_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_chip_select_line_n(cs_n), .i_strobe_osc_off(strb[0]),
    .i_strobe_power_down(strb[1]), .i_strobe_go_idle(strb[2]), .i_strobe_transmit(strb[3]),
    .i_strobe_calibrate(strb[4]), .i_packet_done(strb[5]), .i_fifo_rd(strb[6]), .i_fifo_wr(wr),
    .i_fifo_wdata(wdata), .i_header_active(hdr_act), .i_header_rw(hdr_rw), .i_autocal_select(autocal),
    .i_after_tx_state_select(after_tx), .i_fill_threshold_select(thr), .i_base_freq(base),
    .i_channel_index(chan), .i_spacing_mantissa(mant), .i_spacing_exponent(expo),
    .i_output_pin_select(pin_sel), .o_osc_enable(osc_en), .o_core_reg_enable(core_en),
    .o_chip_ready_indicator_n(rdy_n), .o_config_defaults(cfg_def), .o_state(state), .o_tx_underflow(unf),
    .o_synth_cal_result(cal_res), .o_fifo_rdata(rdata), .o_tx_fill_count(fill), .o_status_fill(sfill),
    .o_threshold_flag(thr_flag), .o_general_output_pin(gpin), .o_carrier_word(carrier));

  rtsc_host_model rtsc_host_model_i (
    .i_chip_ready_indicator_n(rdy_n), .i_status_fill(sfill), .o_chip_select_line_n(cs_n),
    .o_header_active(hdr_act), .o_header_rw(hdr_rw));

  always #12.5 clk = ~clk;
  always @(posedge clk) seen_cfg <= (cfg_def === 1'b1) || (seen_cfg === 1'b1);

  //////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic strobe(input int idx);
    @(posedge clk);
    strb <= 7'h01 << idx;
    @(posedge clk);
    strb <= 7'h00;
    #1;
  endtask

  task automatic wait_st(input logic [3:0] st, input int max);
    for (n = 0; n < max && state !== st; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("state", state, st);
    if (state !== st)
      complete_run();
  endtask

  // cycles spent in a state, counted from the first cycle it shows
  task automatic dwell(input logic [3:0] st, input int exp);
    for (n = 0; n < 30000 && state === st; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("dwell", n, exp);
  endtask

  task automatic reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    wait_st(rtsc_pkg::ST_IDLE, 40);
    chk("ready", rdy_n, 1'b0);
  endtask

  task automatic wait_pwr(input logic osc, input logic core);
    repeat (10) @(posedge clk);
    #1;
    chk("osc_enable", osc_en, osc);
    chk("core_reg", core_en, core);
  endtask

  task automatic push();
    logic [7:0] b;
    logic e;
    b = 8'($random(seed));
    @(posedge clk);
    wr <= 1'b1;
    wdata <= b;
    thr <= 4'($random(seed));
    q.push_back(b);
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
    e = (q.size() >= 61 - 4 * thr);
    chk("fill", fill, q.size());
    chk("thr_flag", thr_flag, e);
    chk("pin_thr", gpin[1], e);
  endtask

  task automatic tx_on();
    strobe(3);
    if (autocal == rtsc_pkg::AUTOCAL_ON_START)
    begin
      chk("state", state, rtsc_pkg::ST_CAL_TX);
      dwell(rtsc_pkg::ST_CAL_TX, 20);
    end
    chk("state", state, rtsc_pkg::ST_SETTLE);
    dwell(rtsc_pkg::ST_SETTLE, SETTLE_N);
    chk("state", state, rtsc_pkg::ST_TX);
  endtask

  task automatic tx_end(input logic [3:0] st, input int cyc);
    strobe(5);
    chk("state", state, st);
    if (cyc > 0)
    begin
      dwell(st, cyc);
      chk("state", state, rtsc_pkg::ST_IDLE);
    end
  endtask

  function automatic logic [26:0] carrier_exp(input logic [23:0] b, input logic [7:0] c,
                                              input logic [7:0] m, input logic [1:0] e);
    carrier_exp = 27'(({3'h0, b} << 2) + ((27'(c) * (27'(m) + 27'h100)) << e));
  endfunction

  //////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    seed = 87;
    bad_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    strb = 7'h00;
    wr = 1'b0;
    wdata = 8'h00;
    autocal = rtsc_pkg::AUTOCAL_NEVER;
    after_tx = rtsc_pkg::AFTER_TX_IDLE;
    thr = 4'h0;
    base = 24'h00_0000;
    chan = 8'h00;
    mant = 8'h00;
    expo = 2'h0;
    pin_sel = {rtsc_pkg::PIN_SEL_THRESH, rtsc_pkg::PIN_SEL_LOCK};
    reset();
    chk("cal_result", cal_res, rtsc_pkg::CAL_RESULT_UNLOCKED);
    strobe(4);
    chk("state", state, rtsc_pkg::ST_CAL_MAN);
    dwell(rtsc_pkg::ST_CAL_MAN, 20);
    chk("state", state, rtsc_pkg::ST_IDLE);
    @(posedge clk);
    #1;
    chk("cal_result", cal_res, rtsc_pkg::CAL_RESULT_LOCKED_DEFAULT);
    chk("pin_lock", gpin[0], 1'b0);
    // frequency settings only touched in idle
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      base <= (i == 0) ? 24'hFF_FFFF : 24'($random(seed));
      chan <= (i == 0) ? 8'hFF : 8'($random(seed));
      mant <= (i == 0) ? 8'hFF : 8'($random(seed));
      expo <= 2'(i);
      repeat (3) @(posedge clk);
      #1;
      chk("carrier", carrier, carrier_exp(base, chan, mant, expo));
    end
    rtsc_host_model_i.select(ok);
    chk("ready", ok, 1'b1);
    // host never writes more than the fifo holds
    for (i = 0; i < 64; i++)
    begin
      push();
      if (i == 4 || i == 63)
      begin
        rtsc_host_model_i.header(1'b0, stat);
        chk("status_fill", stat, (q.size() > 15) ? 15 : q.size());
        rtsc_host_model_i.header(1'b1, stat);
        chk("status_fill", stat, 4'h0);
      end
    end
    rtsc_host_model_i.release_cs();
    tx_on();
    for (i = 0; i < 64; i++)
    begin
      strobe(6);
      chk("rdata", rdata, q.pop_front());
    end
    tx_end(rtsc_pkg::ST_TX_END, 2);
    @(posedge clk);
    after_tx <= rtsc_pkg::AFTER_TX_SYNTH;
    tx_on();
    tx_end(rtsc_pkg::ST_SYNTH_READY, 0);
    strobe(3);
    wait_st(rtsc_pkg::ST_TX, 2400);
    chk("pin_lock", gpin[0], 1'b1);
    @(posedge clk);
    after_tx <= 2'h2;
    tx_end(rtsc_pkg::ST_TX, 0);
    strobe(6);
    chk("state", state, rtsc_pkg::ST_UNDERFLOW);
    chk("underflow", unf, 1'b1);
    strobe(0);
    chk("state", state, rtsc_pkg::ST_UNDERFLOW);
    strobe(2);
    chk("state", state, rtsc_pkg::ST_IDLE);
    chk("underflow", unf, 1'b0);
    @(posedge clk);
    autocal <= rtsc_pkg::AUTOCAL_ON_START;
    after_tx <= rtsc_pkg::AFTER_TX_IDLE;
    tx_on();
    tx_end(rtsc_pkg::ST_TX_END, 2);
    @(posedge clk);
    autocal <= rtsc_pkg::AUTOCAL_ON_END;
    tx_on();
    tx_end(rtsc_pkg::ST_CAL_END, 20);
    tx_on();
    strobe(2);
    chk("state", state, rtsc_pkg::ST_IDLE);
    // fresh counter of automatic exits; the idle-strobe exit must not count
    reset();
    @(posedge clk);
    autocal <= rtsc_pkg::AUTOCAL_FOURTH_END;
    for (i = 0; i < 5; i++)
    begin
      tx_on();
      if (i == 2)
      begin
        strobe(2);
        chk("state", state, rtsc_pkg::ST_IDLE);
      end
      else
        tx_end((i == 4) ? rtsc_pkg::ST_CAL_END : rtsc_pkg::ST_TX_END, (i == 4) ? 20 : 2);
    end
    rtsc_host_model_i.select(ok);
    strobe(0);
    chk("state", state, rtsc_pkg::ST_OSC_OFF);
    rtsc_host_model_i.release_cs();
    wait_pwr(1'b0, 1'b1);
    rtsc_host_model_i.select(ok);
    chk("ready", ok, 1'b1);
    wait_st(rtsc_pkg::ST_IDLE, 40);
    chk("defaults", seen_cfg, 1'b0);
    push();
    strobe(1);
    chk("state", state, rtsc_pkg::ST_SLEEP);
    rtsc_host_model_i.release_cs();
    wait_pwr(1'b0, 1'b0);
    rtsc_host_model_i.select(ok);
    wait_st(rtsc_pkg::ST_IDLE, 40);
    // cal result and the seen flag of the defaults pulse settle one cycle after idle shows
    @(posedge clk);
    #1;
    chk("core_reg", core_en, 1'b1);
    chk("defaults", seen_cfg, 1'b1);
    chk("cal_result", cal_res, rtsc_pkg::CAL_RESULT_UNLOCKED);
    chk("fill", fill, 7'h00);
    rtsc_host_model_i.release_cs();
    complete_run();
  end
endmodule
`default_nettype wire
